// File: uct_pkg.sv
// constants shared by the counter/timer and receive watchdog block
package uct_pkg;

  // ---------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [4:0] IDX_AUX_CTRL  = 5'h04; // write: clock source
  localparam logic [4:0] IDX_INT       = 5'h05; // read status, write mask
  localparam logic [4:0] IDX_UPPER     = 5'h06; // count / preload high
  localparam logic [4:0] IDX_LOWER     = 5'h07; // count / preload low
  localparam logic [4:0] IDX_OUT_CFG   = 5'h0D; // write: output port config
  localparam logic [4:0] IDX_START     = 5'h0E; // read: start command
  localparam logic [4:0] IDX_STOP      = 5'h0F; // read: stop command
  localparam logic [4:0] IDX_BLOCK_CFG = 5'h10; // mode and watchdog enables

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int AUX_SRC_LSB  = 4;  // aux_control_reg bits 6:4
  localparam int OUT_SEL_LSB  = 2;  // output_port_config bits 3:2
  localparam int ISR_WDA_BIT  = 1;
  localparam int ISR_CT_BIT   = 3;
  localparam int ISR_WDB_BIT  = 5;
  localparam int CFG_TIMER    = 0;  // 1 = timer mode
  localparam int CFG_WD_EN    = 1;  // bits 2:1 watchdog enables
  localparam int CFG_RXTO_EN  = 3;  // counter used as receive timeout
  localparam int CFG_RXTO_CH  = 4;  // channel owning the timeout

  // ---------------------------------------------------------------
  // encodings, reset values, timing
  // ---------------------------------------------------------------
  localparam logic [1:0]  OUT_SEL_CT   = 2'h1;   // pin shows counter output
  localparam logic [15:0] RST_PRELOAD  = 16'h0000;
  localparam logic [7:0]  RST_MASK     = 8'h00;
  localparam logic [4:0]  RST_CFG      = 5'h00;  // counter mode after reset
  localparam int          WD_BIT_TIMES = 64;

endpackage

// File: uct_counter_timer.sv
// shared 16-bit counter/timer with per-channel receive watchdogs
`timescale 1ns/1ps
`default_nettype none

module uct_counter_timer
  import uct_pkg::*;
#(
  parameter int CNT_W  = 16,
  parameter int N_SRC  = 8,
  parameter int WD_LEN = WD_BIT_TIMES
) (
  // clock, reset, enable
  input  wire logic             CLK,
  input  wire logic             RESET_N,
  input  wire logic             CE,
  // ahb-lite slave
  input  wire logic             HSEL,
  input  wire logic [31:0]      HADDR,
  input  wire logic [1:0]       HTRANS,
  input  wire logic             HWRITE,
  input  wire logic [2:0]       HSIZE,
  input  wire logic [31:0]      HWDATA,
  input  wire logic             HREADY,
  output logic      [31:0]      HRDATA,
  output logic                  HREADYOUT,
  output logic                  HRESP,
  // counter clock source strobes from on-chip prescalers
  input  wire logic [N_SRC-1:0] CT_SRC_TICK,
  // receiver side, per channel
  input  wire logic [1:0]       RX_PUSH,
  input  wire logic [1:0]       RX_BIT_TICK,
  output logic      [1:0]       RX_TIMEOUT,
  // port and interrupt
  input  wire logic             OP3_DATA,
  output logic                  TIMER_OUTPUT_PIN,
  output logic                  CT_BAUD_CLK,
  output logic                  INTERRUPT_REQUEST_N
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  localparam int WD_W = $clog2(WD_LEN);
  localparam logic [WD_W-1:0]  WD_LAST = WD_W'(WD_LEN - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  typedef struct packed {
    logic [CNT_W-1:0]     preload;
    logic [CNT_W-1:0]     count;
    logic                 running;
    logic                 ct_out;
    logic                 ct_ready;
    logic [2:0]           src_sel;
    logic [1:0]           out_sel;
    logic [7:0]           interrupt_mask;
    logic [4:0]           cfg;
    logic [1:0]           wd_run;
    logic [1:0]           wd_flag;
    logic [1:0][WD_W-1:0] wd_cnt;
    logic                 wr_pend;
    logic [4:0]           wr_idx;
    logic [31:0]          rdata;
  } uct_state_t;

  uct_state_t s;
  uct_state_t next_s;

  logic       acc;
  logic       rd_acc;
  logic [4:0] idx;
  logic       start;
  logic       stop;
  logic       timer;
  logic       tick;
  logic       rx_reload;
  logic       term;
  logic [7:0] interrupt_status_reg;

  // ---------------------------------------------------------------
  // decode and shared terms
  // ---------------------------------------------------------------
  // bus stalls while CE is low so no transfer slips past frozen state
  assign acc    = HSEL & HREADY & HTRANS[1];
  assign rd_acc = acc & ~HWRITE;
  assign idx    = HADDR[6:2];
  assign start  = rd_acc & (idx == IDX_START);
  assign stop   = rd_acc & (idx == IDX_STOP);
  assign timer  = s.cfg[CFG_TIMER];
  assign tick   = CT_SRC_TICK[s.src_sel];
  // only the selected channel reloads the shared counter
  assign rx_reload = s.cfg[CFG_RXTO_EN] & ~timer
                   & RX_PUSH[s.cfg[CFG_RXTO_CH]];
  assign term   = s.running & tick & (s.count == CNT_ONE);

  // status view: counter ready plus the two watchdog flags
  always_comb begin
    interrupt_status_reg = 8'h00;
    interrupt_status_reg[ISR_CT_BIT]  = s.ct_ready;
    interrupt_status_reg[ISR_WDA_BIT] = s.wd_flag[0];
    interrupt_status_reg[ISR_WDB_BIT] = s.wd_flag[1];
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;

    // bus: address phase captured, write lands in data phase
    next_s.wr_pend = acc & HWRITE;
    next_s.wr_idx  = idx;
    if (rd_acc) begin
      next_s.rdata = 32'h0000_0000;
      unique case (idx)
        IDX_INT:       next_s.rdata[7:0] = interrupt_status_reg;
        IDX_UPPER:     next_s.rdata[7:0] = s.count[15:8];
        IDX_LOWER:     next_s.rdata[7:0] = s.count[7:0];
        IDX_BLOCK_CFG: next_s.rdata[4:0] = s.cfg;
        default:       next_s.rdata = 32'h0000_0000;
      endcase
    end
    // write data arrives the cycle after its address was taken
    if (s.wr_pend) begin
      unique case (s.wr_idx)
        IDX_AUX_CTRL:  next_s.src_sel = HWDATA[AUX_SRC_LSB +: 3];
        IDX_INT:       next_s.interrupt_mask = HWDATA[7:0];
        IDX_UPPER:     next_s.preload[15:8] = HWDATA[7:0];
        IDX_LOWER:     next_s.preload[7:0]  = HWDATA[7:0];
        IDX_OUT_CFG:   next_s.out_sel = HWDATA[OUT_SEL_LSB +: 2];
        IDX_BLOCK_CFG: next_s.cfg = HWDATA[4:0];
        default:       next_s.src_sel = s.src_sel;
      endcase
    end

    // counter / timer core; preload only sampled at load points
    if (start) begin
      next_s.count   = s.preload;
      next_s.running = 1'b1;
      if (timer) begin
        next_s.ct_out = 1'b1;
      end
    end else if (rx_reload) begin
      next_s.count   = s.preload;
      next_s.running = 1'b1;
    end else if (s.running && tick) begin
      // reload at one, so each half period is exactly preload ticks
      if (timer && term) begin
        next_s.count  = s.preload;
        next_s.ct_out = ~s.ct_out;
      end else begin
        next_s.count = s.count - CNT_ONE;
      end
    end

    // stop halts only in counter mode; flag clear in both
    if (stop) begin
      if (!timer) begin
        next_s.running = 1'b0;
      end
      next_s.ct_ready = 1'b0;
    end
    // set beats a same-cycle clear
    if (term && !start && !rx_reload) begin
      if (!timer) begin
        next_s.ct_ready = 1'b1;
      end else if (!s.ct_out) begin
        next_s.ct_ready = 1'b1;
      end
    end

    // per-channel watchdogs, clocked by the receiver bit ticks
    // a character in the expiry cycle wins: the line is not idle
    for (int i = 0; i < 2; i++) begin
      if (!s.cfg[CFG_WD_EN + i]) begin
        next_s.wd_run[i]  = 1'b0;
        next_s.wd_flag[i] = 1'b0;
      end else if (RX_PUSH[i]) begin
        next_s.wd_cnt[i]  = '0;
        next_s.wd_run[i]  = 1'b1;
        next_s.wd_flag[i] = 1'b0;
      end else if (s.wd_run[i] && RX_BIT_TICK[i]) begin
        if (s.wd_cnt[i] == WD_LAST) begin
          next_s.wd_run[i]  = 1'b0;
          next_s.wd_flag[i] = 1'b1;
        end else begin
          next_s.wd_cnt[i] = s.wd_cnt[i] + WD_W'(1);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s         <= '0;
      s.preload <= RST_PRELOAD;
      s.interrupt_mask     <= RST_MASK;
      s.cfg     <= RST_CFG;
    end else if (CE) begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign HRDATA     = s.rdata;
  assign HREADYOUT  = CE; // wait states only while frozen
  assign HRESP      = 1'b0;
  assign RX_TIMEOUT = s.wd_flag;
  assign CT_BAUD_CLK = s.ct_out;
  // pin falls back to the plain port bit unless routed
  assign TIMER_OUTPUT_PIN = (s.out_sel == OUT_SEL_CT) ? s.ct_out
                                                      : OP3_DATA;
  assign INTERRUPT_REQUEST_N = ~|(interrupt_status_reg & s.interrupt_mask);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  AST_MODE_ONLY_BY_WRITE: assert property (
    $rose(s.cfg[CFG_TIMER]) |->
      $past(s.wr_pend && s.wr_idx == IDX_BLOCK_CFG && CE))
    else $error("timer mode entered without a config write");

  AST_START_LOADS: assert property (
    (CE && start) |=> (s.running && s.count == $past(s.preload)))
    else $error("start read did not load the preload");

  AST_TERM_SETS_READY: assert property (
    (CE && term && !timer && !start && !rx_reload) |=>
      (s.ct_ready && s.count == 16'h0000))
    else $error("terminal count did not set the ready flag");

  AST_WRAP_FFFF: assert property (
    (CE && s.running && tick && s.count == 16'h0000 && !timer
     && !start && !rx_reload) |=> s.count == 16'hFFFF)
    else $error("count did not wrap to FFFF");

  AST_MASKED_IRQ: assert property (
    (s.ct_ready && !s.interrupt_mask[ISR_CT_BIT] && !(|s.wd_flag))
      |-> INTERRUPT_REQUEST_N)
    else $error("masked counter flag raised the interrupt");

  AST_STOP_HALTS: assert property (
    (CE && stop && !timer && !term) |=>
      (!s.running && !s.ct_ready)
      ##1 ($stable(s.count) || $past(start || rx_reload)))
    else $error("stop did not halt and clear");

  AST_TIMER_NO_STOP: assert property (
    (CE && stop && timer && s.running) |=> s.running)
    else $error("stop halted the timer");

  AST_TIMER_START_HIGH: assert property (
    (CE && start && timer) |=> (s.ct_out && s.count == $past(s.preload)))
    else $error("timer start did not drive output high");

  AST_TIMER_FLAG_RISE: assert property (
    (timer && $rose(s.ct_ready)) |-> $rose(s.ct_out))
    else $error("timer flag not on a rising output edge");

  AST_WD_AFTER_64: assert property (
    $rose(s.wd_flag[0]) |->
      $past(s.wd_cnt[0] == WD_LAST && RX_BIT_TICK[0] && CE))
    else $error("watchdog fired before 64 bit times");

  AST_RXTO_RELOAD: assert property (
    (CE && rx_reload && !start) |=> s.count == $past(s.preload))
    else $error("received character did not reload the counter");

  // counter mode: stepping and the interrupt path
  AST_COUNT_STEP: assert property (
    (CE && !timer && s.running && tick && !start && !rx_reload) |=>
      s.count == $past(s.count) - CNT_ONE)
    else $error("running count did not step down by one");

  AST_IRQ_UNMASKED: assert property (
    (s.ct_ready && s.interrupt_mask[ISR_CT_BIT]) |-> !INTERRUPT_REQUEST_N)
    else $error("unmasked counter flag did not raise the interrupt");

  // timer mode: stop only clears, terminal reloads and toggles
  AST_TIMER_STOP_CLEARS: assert property (
    (CE && stop && timer && !term) |=> !s.ct_ready)
    else $error("stop in timer mode did not clear the flag");

  AST_TIMER_KEEPS_RUNNING: assert property (
    (CE && timer && s.running) |=> s.running)
    else $error("timer stopped counting");

  AST_TIMER_RELOAD: assert property (
    (CE && timer && term && !start) |=>
      (s.count == $past(s.preload) && s.ct_out != $past(s.ct_out)))
    else $error("timer terminal count did not reload and toggle");

  // receive timeout: only the owning channel starts the counter
  AST_RXTO_OWNER: assert property (
    (CE && !s.running && !start && !RX_PUSH[s.cfg[CFG_RXTO_CH]])
      |=> !s.running)
    else $error("counter started by a channel that does not own it");

  AST_RXTO_READY: assert property (
    (CE && term && !timer && s.cfg[CFG_RXTO_EN] && !start && !rx_reload)
      |=> s.ct_ready)
    else $error("receive timeout expiry did not set the ready flag");

  // watchdogs: restart on a character, count own bit ticks only
  AST_WD_PUSH_RESTART: assert property (
    (CE && s.cfg[CFG_WD_EN] && RX_PUSH[0]) |=>
      (s.wd_run[0] && !s.wd_flag[0] && s.wd_cnt[0] == '0))
    else $error("character did not restart watchdog A");

  AST_WD_OWN_TICK: assert property (
    (CE && !RX_BIT_TICK[0] && !RX_PUSH[0]) |=> $stable(s.wd_cnt[0]))
    else $error("watchdog A moved without its bit tick");

  AST_WD_A_DISABLED: assert property (
    (CE && !s.cfg[CFG_WD_EN]) |=> !s.wd_flag[0])
    else $error("disabled watchdog A still shows a timeout");

  AST_WD_B_AFTER_64: assert property (
    $rose(s.wd_flag[1]) |->
      $past(s.wd_cnt[1] == WD_LAST && RX_BIT_TICK[1] && CE))
    else $error("watchdog B fired before 64 bit times");

  AST_WD_B_PUSH_RESTART: assert property (
    (CE && s.cfg[CFG_WD_EN + 1] && RX_PUSH[1]) |=>
      (s.wd_run[1] && !s.wd_flag[1] && s.wd_cnt[1] == '0))
    else $error("character did not restart watchdog B");

  AST_WD_B_OWN_TICK: assert property (
    (CE && !RX_BIT_TICK[1] && !RX_PUSH[1]) |=> $stable(s.wd_cnt[1]))
    else $error("watchdog B moved without its bit tick");

  AST_WD_B_DISABLED: assert property (
    (CE && !s.cfg[CFG_WD_EN + 1]) |=> !s.wd_flag[1])
    else $error("disabled watchdog B still shows a timeout");

  // main scenarios the tests should reach
  COV_COUNTER_TERM: cover property (CE && term && !timer);
  COV_TIMER_FLAG: cover property (timer && $rose(s.ct_ready));
  COV_WD_EXPIRE: cover property ($rose(s.wd_flag[1]));
  COV_RXTO_EXPIRE: cover property (
    CE && term && s.cfg[CFG_RXTO_EN] && !timer);
  COV_COUNTER_STOP: cover property (CE && stop && !timer && s.running);

endmodule

`default_nettype wire

// File: tb_uct_counter_timer.sv
// self-checking bench for the counter/timer and receive watchdog block
`timescale 1ns/1ps
`default_nettype none
module tb_uct_counter_timer;
  import uct_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        CLK = 1'b0;
  logic        RESET_N = 1'b0;
  logic        HSEL = 1'b0;
  logic        HWRITE = 1'b0;
  logic [1:0]  HTRANS = 2'h0;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic        HREADYOUT;
  logic        HRESP;
  logic [7:0]  CT_SRC_TICK = 8'h00;
  logic [1:0]  RX_PUSH = 2'h0;
  logic [1:0]  RX_BIT_TICK = 2'h0;
  logic [1:0]  RX_TIMEOUT;
  logic        OP3_DATA = 1'b0;
  logic        TIMER_OUTPUT_PIN;
  logic        CT_BAUD_CLK;
  logic        INTERRUPT_REQUEST_N;
  int          err_count = 0;
  int          checks_done = 0;

  // short watchdog so a timeout takes a handful of bit ticks
  uct_counter_timer #(.WD_LEN(4)) i_uct_counter_timer (
    .CLK(CLK), .RESET_N(RESET_N), .CE(1'b1),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .CT_SRC_TICK(CT_SRC_TICK), .RX_PUSH(RX_PUSH), .RX_BIT_TICK(RX_BIT_TICK),
    .RX_TIMEOUT(RX_TIMEOUT), .OP3_DATA(OP3_DATA), .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN),
    .CT_BAUD_CLK(CT_BAUD_CLK), .INTERRUPT_REQUEST_N(INTERRUPT_REQUEST_N)
  );

  // 40 MHz clock
  always #12.5 CLK = ~CLK;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  // one single transfer; returns after settling, well away from an edge
  task automatic bus(input logic [4:0] idx, input logic is_wr, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= is_wr;
    HADDR <= {25'h0, idx, 2'h0};
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= {24'h0, wd};
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA[7:0];
    @(negedge CLK);
  endtask

  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus(idx, 1'b1, d, x);
  endtask

  task automatic rd_chk(input logic [4:0] idx, input logic [7:0] exp);
    logic [7:0] x;
    bus(idx, 1'b0, 8'h00, x);
    chk(x, exp);
  endtask

  // n one-cycle strobes with a gap between them
  task automatic pulse(input int n, input logic [7:0] src, input logic [1:0] push, input logic [1:0] bt);
    for (int i = 0; i < n; i++) begin
      @(posedge CLK);
      CT_SRC_TICK <= src;
      RX_PUSH <= push;
      RX_BIT_TICK <= bt;
      @(posedge CLK);
      CT_SRC_TICK <= 8'h00;
      RX_PUSH <= 2'h0;
      RX_BIT_TICK <= 2'h0;
    end
    @(negedge CLK);
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #500000;
    err_count++;
    close_out();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge CLK);
    RESET_N <= 1'b1;
    @(negedge CLK);
    chk(INTERRUPT_REQUEST_N, 8'h01);
    chk(CT_BAUD_CLK, 8'h00);
    chk(HRESP, 8'h00);
    rd_chk(IDX_BLOCK_CFG, 8'h00);
    $display("reset test done");
    // counter mode on source 3, preload 3
    wr(IDX_AUX_CTRL, 8'h30);
    wr(IDX_UPPER, 8'h00);
    wr(IDX_LOWER, 8'h03);
    rd_chk(IDX_START, 8'h00);
    pulse(2, 8'h08, 2'h0, 2'h0);
    pulse(2, 8'h01, 2'h0, 2'h0);
    rd_chk(IDX_INT, 8'h00);
    pulse(1, 8'h08, 2'h0, 2'h0);
    rd_chk(IDX_INT, 8'h08);
    chk(INTERRUPT_REQUEST_N, 8'h01);
    wr(IDX_INT, 8'h08);
    chk(INTERRUPT_REQUEST_N, 8'h00);
    wr(IDX_LOWER, 8'h09);
    pulse(1, 8'h08, 2'h0, 2'h0);
    rd_chk(IDX_STOP, 8'h00);
    pulse(2, 8'h08, 2'h0, 2'h0);
    rd_chk(IDX_UPPER, 8'hFF);
    rd_chk(IDX_LOWER, 8'hFF);
    rd_chk(IDX_INT, 8'h00);
    chk(INTERRUPT_REQUEST_N, 8'h01);
    $display("counter test done");
    // timer mode, preload 2, output routed to the pin
    wr(IDX_BLOCK_CFG, 8'h01);
    wr(IDX_LOWER, 8'h02);
    rd_chk(IDX_START, 8'h00);
    chk(CT_BAUD_CLK, 8'h01);
    wr(IDX_OUT_CFG, 8'h04);
    chk(TIMER_OUTPUT_PIN, 8'h01);
    pulse(2, 8'h08, 2'h0, 2'h0);
    chk(CT_BAUD_CLK, 8'h00);
    rd_chk(IDX_INT, 8'h00);
    pulse(2, 8'h08, 2'h0, 2'h0);
    chk(CT_BAUD_CLK, 8'h01);
    rd_chk(IDX_INT, 8'h08);
    rd_chk(IDX_STOP, 8'h00);
    rd_chk(IDX_INT, 8'h00);
    pulse(2, 8'h08, 2'h0, 2'h0);
    chk(CT_BAUD_CLK, 8'h00);
    wr(IDX_LOWER, 8'h01);
    pulse(2, 8'h08, 2'h0, 2'h0);
    chk(CT_BAUD_CLK, 8'h01);
    pulse(1, 8'h08, 2'h0, 2'h0);
    chk(CT_BAUD_CLK, 8'h00);
    @(posedge CLK);
    OP3_DATA <= 1'b1;
    wr(IDX_OUT_CFG, 8'h00);
    chk(TIMER_OUTPUT_PIN, 8'h01);
    rd_chk(IDX_STOP, 8'h00);
    $display("timer test done");
    // watchdog A, four bit times in this build
    wr(IDX_BLOCK_CFG, 8'h02);
    pulse(1, 8'h00, 2'h1, 2'h0);
    pulse(3, 8'h00, 2'h0, 2'h3);
    pulse(1, 8'h00, 2'h1, 2'h0);
    pulse(3, 8'h00, 2'h0, 2'h3);
    repeat (2) @(negedge CLK);
    chk(RX_TIMEOUT, 8'h00);
    pulse(1, 8'h00, 2'h0, 2'h1);
    repeat (2) @(negedge CLK);
    chk(RX_TIMEOUT, 8'h01);
    rd_chk(IDX_INT, 8'h02);
    pulse(1, 8'h00, 2'h1, 2'h0);
    chk(RX_TIMEOUT, 8'h00);
    pulse(4, 8'h00, 2'h0, 2'h2);
    chk(RX_TIMEOUT, 8'h00);
    $display("watchdog test done");
    // counter as receive timeout for channel A, preload 3
    wr(IDX_BLOCK_CFG, 8'h08);
    rd_chk(IDX_STOP, 8'h00);
    wr(IDX_LOWER, 8'h03);
    pulse(1, 8'h00, 2'h1, 2'h0);
    pulse(2, 8'h08, 2'h0, 2'h0);
    pulse(1, 8'h00, 2'h1, 2'h0);
    pulse(2, 8'h08, 2'h0, 2'h0);
    rd_chk(IDX_INT, 8'h00);
    pulse(1, 8'h00, 2'h2, 2'h0);
    pulse(1, 8'h08, 2'h0, 2'h0);
    rd_chk(IDX_INT, 8'h08);
    rd_chk(IDX_LOWER, 8'h00);
    $display("receive timeout test done");
    close_out();
  end
endmodule
`default_nettype wire
